// ### rtl/kds_pkg.sv
`default_nettype none

package kds_pkg;

	// ----------------------------------------------------------------
	// register map (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [7:0] ADDR_MODE = 8'h00;
	localparam logic [7:0] ADDR_PRESCALE = 8'h04;
	localparam logic [7:0] ADDR_BLANK = 8'h08;
	localparam logic [7:0] ADDR_CLEAR = 8'h0C;
	localparam logic [7:0] ADDR_RAM_PTR = 8'h10;
	localparam logic [7:0] ADDR_RAM_DATA = 8'h14;
	localparam logic [7:0] ADDR_FIFO = 8'h18;
	localparam logic [7:0] ADDR_STATUS = 8'h1C;

	// ----------------------------------------------------------------
	// fields and reset values
	// ----------------------------------------------------------------
	localparam logic [2:0] KBD_MODE_RESET = 3'h0;
	localparam logic [1:0] DISP_MODE_RESET = 2'h1;
	localparam int MODE_DISP_LSB = 3;
	localparam logic [4:0] PRESCALE_RESET = 5'h1F;
	localparam logic [4:0] PRESCALE_MIN = 5'h02;
	localparam int BLANK_B_BIT = 0;
	localparam int BLANK_A_BIT = 1;
	localparam int INHIBIT_B_BIT = 2;
	localparam int INHIBIT_A_BIT = 3;
	localparam int CLEAR_EN_BIT = 1;
	localparam int CLEAR_SEL_BIT = 0;
	localparam int CLEAR_ENABLE_BIT = 2;
	localparam int RAM_AI_BIT = 4;
	localparam int STATUS_OVR_BIT = 5;
	localparam logic [7:0] CLEAR_FILL_ZERO = 8'h00;
	localparam logic [7:0] CLEAR_FILL_SPACE = 8'h20;
	localparam logic [7:0] CLEAR_FILL_ONES = 8'hFF;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int SCAN_PW_US = 640;
	localparam int REF_INT_CLK_KHZ = 100;
	localparam int PW_TICKS = SCAN_PW_US * REF_INT_CLK_KHZ / 1000;
	localparam int KEY_ROWS = 8;
	localparam int DECODED_ROWS = 4;
	localparam int DEB_SCANS = 2;
	localparam int DEB_ROWS = DEB_SCANS * KEY_ROWS;
	localparam int FIFO_DEPTH = 8;
	localparam int RAM_DEPTH = 16;

endpackage

`default_nettype wire

// ### rtl/kds_scanner.sv
// Our own choices: the APB interface to the registers and the address map.
`default_nettype none

module kds_scanner
(
	// apb slave
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// key matrix
	input wire logic [7:0] key_return_in,
	input wire logic shift_key_in,
	input wire logic ctrl_key_in,
	// scan and display
	output logic [3:0] scan_timing_out,
	output logic [3:0] disp_group_a_out,
	output logic [3:0] disp_group_b_out,
	output logic display_blank_n,
	output logic key_irq
);

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	logic [2:0] keyboard_mode_field;
	logic [1:0] display_mode_field;
	logic [4:0] prescale;
	logic blank_a, blank_b, inhibit_a, inhibit_b;
	logic [3:0] ram_ptr;
	logic ram_ai;
	logic overrun;
	logic disp_live;
	logic [7:0] ram [kds_pkg::RAM_DEPTH];

	logic wr_acc, rd_acc, setup;
	logic clear_go;
	logic [7:0] clear_fill;
	logic ram_wr;

	assign setup = psel & ~penable;
	assign wr_acc = psel & penable & pwrite;
	assign rd_acc = psel & penable & ~pwrite;
	assign pready = 1'b1;
	assign clear_go = wr_acc && paddr == kds_pkg::ADDR_CLEAR && pwdata[kds_pkg::CLEAR_ENABLE_BIT];
	assign ram_wr = wr_acc && paddr == kds_pkg::ADDR_RAM_DATA;

	always_comb
	begin
		unique case (paddr)
			kds_pkg::ADDR_MODE, kds_pkg::ADDR_PRESCALE, kds_pkg::ADDR_BLANK, kds_pkg::ADDR_CLEAR,
			kds_pkg::ADDR_RAM_PTR, kds_pkg::ADDR_RAM_DATA, kds_pkg::ADDR_FIFO, kds_pkg::ADDR_STATUS:
				pslverr = 1'b0;
			default:
				pslverr = psel & penable;
		endcase
	end

	// clear pattern select: 0x -> zeros, 10 -> space code, 11 -> ones
	always_comb
	begin
		if (!pwdata[kds_pkg::CLEAR_EN_BIT])
			clear_fill = kds_pkg::CLEAR_FILL_ZERO;
		else if (!pwdata[kds_pkg::CLEAR_SEL_BIT])
			clear_fill = kds_pkg::CLEAR_FILL_SPACE;
		else
			clear_fill = kds_pkg::CLEAR_FILL_ONES;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			keyboard_mode_field <= kds_pkg::KBD_MODE_RESET;
			display_mode_field <= kds_pkg::DISP_MODE_RESET;
			prescale <= kds_pkg::PRESCALE_RESET;
			blank_a <= 1'b0;
			blank_b <= 1'b0;
			inhibit_a <= 1'b0;
			inhibit_b <= 1'b0;
		end
		else if (wr_acc)
		begin
			if (paddr == kds_pkg::ADDR_MODE)
			begin
				keyboard_mode_field <= pwdata[2:0];
				display_mode_field <= pwdata[kds_pkg::MODE_DISP_LSB +: 2];
			end
			if (paddr == kds_pkg::ADDR_PRESCALE)
				prescale <= pwdata[4:0];
			if (paddr == kds_pkg::ADDR_BLANK)
			begin
				blank_a <= pwdata[kds_pkg::BLANK_A_BIT];
				blank_b <= pwdata[kds_pkg::BLANK_B_BIT];
				inhibit_a <= pwdata[kds_pkg::INHIBIT_A_BIT];
				inhibit_b <= pwdata[kds_pkg::INHIBIT_B_BIT];
			end
		end
	end

	// display ram pointer with optional auto-increment
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ram_ptr <= 4'h0;
			ram_ai <= 1'b0;
		end
		else if (wr_acc && paddr == kds_pkg::ADDR_RAM_PTR)
		begin
			ram_ptr <= pwdata[3:0];
			ram_ai <= pwdata[kds_pkg::RAM_AI_BIT];
		end
		else if (ram_ai && paddr == kds_pkg::ADDR_RAM_DATA && psel && penable)
			ram_ptr <= ram_ptr + 4'h1;
	end

	// group A and B outputs stay low until the first clear has defined the ram
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			disp_live <= 1'b0;
		else if (clear_go)
			disp_live <= 1'b1;
	end

	// ----------------------------------------------------------------
	// display ram: no reset, only the clear command empties it
	// ----------------------------------------------------------------
	generate
		for (genvar i = 0; i < kds_pkg::RAM_DEPTH; i++)
		begin : g_ram
			always_ff @(posedge pclk)
			begin
				if (clear_go)
					ram[i] <= clear_fill;
				else if (ram_wr && ram_ptr == 4'(i))
				begin
					if (!inhibit_a)
						ram[i][7:4] <= pwdata[7:4];
					if (!inhibit_b)
						ram[i][3:0] <= pwdata[3:0];
				end
			end
		end
	endgenerate

	// ----------------------------------------------------------------
	// input synchronisers, pulled-up lines read low when closed
	// ----------------------------------------------------------------
	logic [9:0] in_s1, in_s2, in_s3, in_f;
	logic [9:0] in_diff;

	assign in_diff = in_s2 ^ in_s3;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			in_s1 <= '1;
			in_s2 <= '1;
			in_s3 <= '1;
			in_f <= '1;
		end
		else
		begin
			in_s1 <= {ctrl_key_in, shift_key_in, key_return_in};
			in_s2 <= in_s1;
			in_s3 <= in_s2;
			in_f <= (in_s2 & ~in_diff) | (in_f & in_diff);
		end
	end

	// ----------------------------------------------------------------
	// prescaler and scan counter
	// ----------------------------------------------------------------
	logic [4:0] pre_cnt;
	logic [4:0] pre_lim;
	logic tick;
	logic [5:0] pw_cnt;
	logic [3:0] scan_cnt;
	logic row_done;

	assign pre_lim = (prescale < kds_pkg::PRESCALE_MIN) ? kds_pkg::PRESCALE_MIN : prescale;
	assign tick = (pre_cnt == pre_lim - 5'h01);
	assign row_done = tick && pw_cnt == 6'(kds_pkg::PW_TICKS - 1);

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			pre_cnt <= 5'h00;
		else if (tick || pre_cnt >= pre_lim)
			pre_cnt <= 5'h00;
		else
			pre_cnt <= pre_cnt + 5'h01;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pw_cnt <= 6'h00;
			scan_cnt <= 4'h0;
		end
		else if (row_done)
		begin
			pw_cnt <= 6'h00;
			scan_cnt <= scan_cnt + 4'h1;
		end
		else if (tick)
			pw_cnt <= pw_cnt + 6'h01;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			scan_timing_out <= 4'h0;
		else if (keyboard_mode_field[0])
			scan_timing_out <= 4'h1 << scan_cnt[1:0];
		else
			scan_timing_out <= scan_cnt;
	end

	// ----------------------------------------------------------------
	// key debounce, two-key lockout
	// ----------------------------------------------------------------
	logic [63:0] key_down;
	logic [2:0] row;
	logic row_ok;
	logic [7:0] row_closed, new_bits, other_bits;
	logic [2:0] new_col;
	logic has_new;
	logic [5:0] cand;
	logic cand_valid, other_down;
	logic [4:0] deb_cnt;
	logic cand_in_row, still_down, deb_end, lockout, fifo_push;

	assign row = scan_cnt[2:0];
	// decoded mode scans only four rows but keeps the same cycle length
	assign row_ok = !keyboard_mode_field[0] || row < 3'(kds_pkg::DECODED_ROWS);
	assign row_closed = row_ok ? ~in_f[7:0] : 8'h00;
	assign new_bits = row_closed & ~key_down[row * 8 +: 8];
	assign has_new = |new_bits;
	assign lockout = keyboard_mode_field[2:1] == 2'h0;
	assign cand_in_row = cand[5:3] == row;
	assign other_bits = row_closed & ~(cand_in_row ? 8'h01 << cand[2:0] : 8'h00);
	assign still_down = cand_in_row ? row_closed[cand[2:0]] : key_down[cand];
	assign deb_end = cand_valid && deb_cnt == 5'(kds_pkg::DEB_ROWS - 1);
	assign fifo_push = row_done && lockout && !has_new && deb_end && still_down
		&& !other_down && !(|other_bits);

	always_comb
	begin
		new_col = 3'h0;
		for (int c = 0; c < 8; c++)
			if (new_bits[c])
				new_col = 3'(c);
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			key_down <= '0;
		else if (row_done)
			key_down[row * 8 +: 8] <= row_closed;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cand <= 6'h00;
			cand_valid <= 1'b0;
			other_down <= 1'b0;
			deb_cnt <= 5'h00;
		end
		else if (row_done && lockout)
		begin
			if (has_new)
			begin
				cand <= {row, new_col};
				cand_valid <= 1'b1;
				deb_cnt <= 5'h00;
				other_down <= |(row_closed & ~(8'h01 << new_col));
			end
			else if (cand_valid)
			begin
				other_down <= other_down | (|other_bits);
				if (deb_end)
					cand_valid <= 1'b0;
				else
					deb_cnt <= deb_cnt + 5'h01;
			end
		end
		else if (!lockout)
			cand_valid <= 1'b0;
	end

	// ----------------------------------------------------------------
	// key fifo
	// ----------------------------------------------------------------
	logic [7:0] fifo_mem [kds_pkg::FIFO_DEPTH];
	logic [2:0] wr_ptr, rd_ptr;
	logic [3:0] fifo_cnt;
	logic fifo_full, fifo_pop, do_push;

	assign fifo_full = fifo_cnt == 4'(kds_pkg::FIFO_DEPTH);
	assign fifo_pop = rd_acc && paddr == kds_pkg::ADDR_FIFO && fifo_cnt != 4'h0;
	assign do_push = fifo_push && !fifo_full;
	assign key_irq = fifo_cnt != 4'h0;

	always_ff @(posedge pclk)
	begin
		if (do_push)
			fifo_mem[wr_ptr] <= {in_f[9], in_f[8], cand};
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			wr_ptr <= 3'h0;
			rd_ptr <= 3'h0;
			fifo_cnt <= 4'h0;
		end
		else
		begin
			if (do_push)
				wr_ptr <= wr_ptr + 3'h1;
			if (fifo_pop)
				rd_ptr <= rd_ptr + 3'h1;
			fifo_cnt <= fifo_cnt + 4'(do_push) - 4'(fifo_pop);
		end
	end

	// lost entry flag: a new loss wins over a same-cycle clear
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			overrun <= 1'b0;
		else if (fifo_push && fifo_full)
			overrun <= 1'b1;
		else if (wr_acc && paddr == kds_pkg::ADDR_STATUS && pwdata[kds_pkg::STATUS_OVR_BIT])
			overrun <= 1'b0;
	end

	// ----------------------------------------------------------------
	// read data, captured in the setup cycle
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata <= 32'h0;
		else if (setup && !pwrite)
		begin
			unique case (paddr)
				kds_pkg::ADDR_MODE: prdata <= {27'h0, display_mode_field, keyboard_mode_field};
				kds_pkg::ADDR_PRESCALE: prdata <= {27'h0, prescale};
				kds_pkg::ADDR_BLANK: prdata <= {28'h0, inhibit_a, inhibit_b, blank_a, blank_b};
				kds_pkg::ADDR_RAM_PTR: prdata <= {27'h0, ram_ai, ram_ptr};
				kds_pkg::ADDR_RAM_DATA: prdata <= {24'h0, ram[ram_ptr]};
				kds_pkg::ADDR_FIFO: prdata <= {24'h0, fifo_mem[rd_ptr]};
				kds_pkg::ADDR_STATUS: prdata <= {26'h0, overrun, 1'b0, fifo_cnt};
				default: prdata <= 32'h0;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// display outputs
	// ----------------------------------------------------------------
	logic [3:0] digit;

	assign digit = display_mode_field[0] ? scan_cnt : {1'b0, scan_cnt[2:0]};

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			disp_group_a_out <= 4'h0;
			disp_group_b_out <= 4'h0;
			display_blank_n <= 1'b1;
		end
		else
		begin
			disp_group_a_out <= (disp_live && !blank_a) ? ram[digit][7:4] : 4'h0;
			disp_group_b_out <= (disp_live && !blank_b) ? ram[digit][3:0] : 4'h0;
			display_blank_n <= !(blank_a && blank_b);
		end
	end

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	a_decoded_scan: assert property (@(posedge pclk) disable iff (!presetn)
		keyboard_mode_field[0] && $stable(keyboard_mode_field) |=> scan_timing_out == 4'h1 << $past(scan_cnt[1:0]))
		else $error("decoded scan output wrong");
	a_encoded_scan: assert property (@(posedge pclk) disable iff (!presetn)
		!keyboard_mode_field[0] && $stable(keyboard_mode_field) |=> scan_timing_out == $past(scan_cnt))
		else $error("encoded scan output wrong");
	a_pulse_width: assert property (@(posedge pclk) disable iff (!presetn)
		scan_cnt != $past(scan_cnt) |-> $past(pw_cnt) == 6'(kds_pkg::PW_TICKS - 1) && $past(tick))
		else $error("scan step not at pulse end");
	a_push_end: assert property (@(posedge pclk) disable iff (!presetn)
		fifo_push |-> deb_cnt == 5'(kds_pkg::DEB_ROWS - 1) && row_done && cand_valid)
		else $error("entry before debounce end");
	a_new_restart: assert property (@(posedge pclk) disable iff (!presetn)
		row_done && lockout && has_new |=> deb_cnt == 5'h00 && cand_valid && cand[5:3] == $past(row))
		else $error("new key did not restart debounce");
	a_push_irq: assert property (@(posedge pclk) disable iff (!presetn)
		do_push && !fifo_pop |=> key_irq && fifo_cnt == $past(fifo_cnt) + 4'h1)
		else $error("entry did not raise request");
	a_lone_key: assert property (@(posedge pclk) disable iff (!presetn)
		fifo_push |-> !other_down && still_down && !has_new)
		else $error("key entered with another held");
	a_decoded_rows: assert property (@(posedge pclk) disable iff (!presetn)
		keyboard_mode_field[0] && row >= 3'(kds_pkg::DECODED_ROWS) |-> row_closed == 8'h00)
		else $error("decoded mode scanned upper rows");
	a_dark_reset: assert property (@(posedge pclk) disable iff (!presetn)
		!disp_live |=> disp_group_a_out == 4'h0 && disp_group_b_out == 4'h0)
		else $error("display driven before clear");
	a_nibble_map: assert property (@(posedge pclk) disable iff (!presetn)
		disp_live && !blank_a && !clear_go && !ram_wr |=> disp_group_a_out == $past(ram[digit][7:4]))
		else $error("group A not from high nibble");
	a_blank_out: assert property (@(posedge pclk) disable iff (!presetn)
		blank_a && blank_b |=> !display_blank_n)
		else $error("blank output not low");

	c_key_entered: cover property (@(posedge pclk) disable iff (!presetn) do_push);
	c_restart_mid: cover property (@(posedge pclk) disable iff (!presetn) row_done && has_new && cand_valid);
	c_overrun: cover property (@(posedge pclk) disable iff (!presetn) fifo_push && fifo_full);
	c_clear_run: cover property (@(posedge pclk) disable iff (!presetn) clear_go);

endmodule

`default_nettype wire

// ### bench/kds_matrix_model.sv
`default_nettype none

module kds_matrix_model
(
	// scan side
	input wire logic [3:0] scan_timing_out,
	input wire logic decoded,
	// switch state
	input wire logic [63:0] pressed,
	input wire logic shift_pressed,
	input wire logic ctrl_pressed,
	// return side
	output logic [7:0] key_return_in,
	output logic shift_key_in,
	output logic ctrl_key_in
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [2:0] row;
	logic row_on;

	// ----------------------------------------------------------------
	// row decoder
	// ----------------------------------------------------------------
	// key decoder of its own, fed by the three low scan lines when encoded and all four when decoded
	always_comb
	begin
		row = scan_timing_out[2:0];
		row_on = 1'b1;
		if (decoded)
		begin
			row_on = $onehot(scan_timing_out);
			row = {1'b0, scan_timing_out[3] | scan_timing_out[2], scan_timing_out[3] | scan_timing_out[1]};
		end
	end

	// ----------------------------------------------------------------
	// return lines
	// ----------------------------------------------------------------
	// pull-ups hold open lines high; a closed switch pulls its line low
	assign key_return_in = row_on ? ~pressed[{row, 3'h0} +: 8] : 8'hFF;
	assign shift_key_in = ~shift_pressed;
	assign ctrl_key_in = ~ctrl_pressed;

endmodule

`default_nettype wire

// ### bench/tb.sv
`default_nettype none

module tb;
	timeunit 1ns;
	timeprecision 1ps;

	localparam int ROW = 128;
	localparam int LO = 15 * ROW;
	localparam int HI = 25 * ROW;

	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, perr;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rdat;
	logic [7:0] key_return_in;
	logic shift_key_in, ctrl_key_in, display_blank_n, key_irq, decoded, shift_pressed, ctrl_pressed;
	logic [3:0] scan_timing_out, disp_group_a_out, disp_group_b_out, prev;
	logic [63:0] pressed;
	int n_fail, checks, t;

	kds_scanner kds_scanner_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .key_return_in(key_return_in), .shift_key_in(shift_key_in),
		.ctrl_key_in(ctrl_key_in), .scan_timing_out(scan_timing_out), .disp_group_a_out(disp_group_a_out),
		.disp_group_b_out(disp_group_b_out), .display_blank_n(display_blank_n), .key_irq(key_irq));

	kds_matrix_model kds_matrix_model_inst (.scan_timing_out(scan_timing_out), .decoded(decoded),
		.pressed(pressed), .shift_pressed(shift_pressed), .ctrl_pressed(ctrl_pressed),
		.key_return_in(key_return_in), .shift_key_in(shift_key_in), .ctrl_key_in(ctrl_key_in));

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	task automatic print_verdict();
		$display("checks %0d, failures %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		checks++;
		if (got !== exp)
		begin
			n_fail++;
			$display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask

	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1)
		begin
			@(posedge pclk);
		end
		rdat = prdata;
		perr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
		apb(1'b0, a, 32'h0);
		chk(rdat, exp, what);
	endtask

	task automatic do_reset();
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		@(negedge pclk);
	endtask

	task automatic next_step();
		prev = scan_timing_out;
		t = 0;
		while (scan_timing_out === prev && t < 4000)
		begin
			@(negedge pclk);
			t++;
		end
	endtask

	task automatic fill_ram();
		apb(1'b1, kds_pkg::ADDR_RAM_PTR, 32'h10);
		for (int k = 0; k < 16; k++)
			apb(1'b1, kds_pkg::ADDR_RAM_DATA, {24'h0, 4'(k), ~4'(k)});
	endtask

	task automatic hold_keys(input logic [63:0] keys, input int cycles);
		@(posedge pclk);
		pressed <= keys;
		t = 0;
		while (key_irq !== 1'b1 && t < cycles)
		begin
			@(negedge pclk);
			t++;
		end
	endtask

	// a lone held key enters once, after one debounce interval
	task automatic key_case(input logic [63:0] keys, input logic [31:0] code);
		hold_keys(keys, HI);
		chk(32'(t >= LO && t < HI), 1, "entry delay");
		rd(kds_pkg::ADDR_FIFO, code, "key code");
		repeat (4) @(negedge pclk);
		chk(key_irq, 1'b0, "irq after pop");
		repeat (24 * ROW) @(negedge pclk);
		rd(kds_pkg::ADDR_STATUS, 32'h0, "held key once");
		hold_keys(64'h0, 10 * ROW);
	endtask

	// ----------------------------------------------------------------
	// clock and watchdog
	// ----------------------------------------------------------------
	initial
	begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end

	initial
	begin
		#1_000_000;
		n_fail++;
		$display("Error at %0t: watchdog expired", $time);
		print_verdict();
	end

	// ----------------------------------------------------------------
	// tests
	// ----------------------------------------------------------------
	initial
	begin
		static logic [7:0] clr_cmd [3] = '{8'h07, 8'h06, 8'h04};
		static logic [7:0] clr_exp [3] = '{8'hFF, 8'h20, 8'h00};
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h0;
		pwdata = 32'h0;
		pressed = 64'h0;
		decoded = 1'b0;
		shift_pressed = 1'b0;
		ctrl_pressed = 1'b0;
		do_reset();
		rd(kds_pkg::ADDR_MODE, 32'h08, "mode reset");
		rd(kds_pkg::ADDR_PRESCALE, 32'h1F, "prescale reset");
		chk({display_blank_n, key_irq, disp_group_a_out, disp_group_b_out}, 32'h200, "reset outputs");
		rd(8'h20, 32'h0, "unmapped read");
		chk(perr, 1'b1, "unmapped error");
		apb(1'b1, kds_pkg::ADDR_PRESCALE, 32'h2);
		fill_ram();
		next_step();
		next_step();
		chk(t, ROW, "pulse width");
		chk({disp_group_a_out, disp_group_b_out}, 32'h0, "dark before clear");
		for (int k = 0; k < 3; k++)
		begin
			apb(1'b1, kds_pkg::ADDR_CLEAR, {24'h0, clr_cmd[k]});
			next_step();
			next_step();
			chk({disp_group_a_out, disp_group_b_out}, clr_exp[k], "clear fill");
		end
		fill_ram();
		next_step();
		for (int k = 0; k < 16; k++)
		begin
			next_step();
			repeat (8) @(negedge pclk);
			chk(scan_timing_out, 4'(prev + 4'h1), "encoded count");
			chk({disp_group_a_out, disp_group_b_out}, {scan_timing_out, ~scan_timing_out}, "digit");
		end
		apb(1'b1, kds_pkg::ADDR_BLANK, 32'h3);
		repeat (4) @(negedge pclk);
		chk({display_blank_n, disp_group_a_out, disp_group_b_out}, 32'h0, "both blanked");
		apb(1'b1, kds_pkg::ADDR_BLANK, 32'h2);
		repeat (4) @(negedge pclk);
		chk({display_blank_n, disp_group_a_out}, 32'h10, "one blanked");
		apb(1'b1, kds_pkg::ADDR_BLANK, 32'h0);
		shift_pressed <= 1'b1;
		key_case(64'h1 << 29, 32'h9D);
		shift_pressed <= 1'b0;
		hold_keys((64'h1 << 10) | (64'h1 << 44), 5 * 8 * ROW);
		chk(key_irq, 1'b0, "two keys");
		hold_keys(64'h0, 16 * ROW);
		hold_keys(64'h1 << 20, 8 * ROW);
		hold_keys(64'h0, 24 * ROW);
		chk(key_irq, 1'b0, "released early");
		hold_keys(64'h1 << 33, 8 * ROW);
		key_case(64'h1 << 50, 32'hF2);
		apb(1'b1, kds_pkg::ADDR_MODE, 32'h00);
		next_step();
		for (int k = 0; k < 8; k++)
		begin
			next_step();
			repeat (8) @(negedge pclk);
			chk(disp_group_a_out, {1'b0, scan_timing_out[2:0]}, "eight digits");
		end
		apb(1'b1, kds_pkg::ADDR_MODE, 32'h0A);
		hold_keys(64'h1 << 9, 24 * ROW);
		chk(key_irq, 1'b0, "no entry outside lockout");
		hold_keys(64'h0, 10 * ROW);
		apb(1'b1, kds_pkg::ADDR_MODE, 32'h09);
		decoded <= 1'b1;
		next_step();
		for (int k = 0; k < 4; k++)
		begin
			next_step();
			chk($countones(scan_timing_out), 1, "one-hot");
			chk(scan_timing_out, {prev[2:0], prev[3]}, "decoded order");
		end
		ctrl_pressed <= 1'b1;
		key_case(64'h1 << 9, 32'h49);
		ctrl_pressed <= 1'b0;
		do_reset();
		chk({disp_group_a_out, disp_group_b_out}, 32'h0, "dark after reset");
		rd(kds_pkg::ADDR_MODE, 32'h08, "mode second reset");
		apb(1'b1, kds_pkg::ADDR_RAM_PTR, 32'h10);
		for (int k = 0; k < 16; k++)
			rd(kds_pkg::ADDR_RAM_DATA, {24'h0, 4'(k), ~4'(k)}, "ram kept");
		print_verdict();
	end

endmodule

`default_nettype wire
